//--- verilog/pllddl_pkg.sv
package pllddl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_PRESCALE = 6'h00;
    localparam logic [5:0] OFS_A_COUNT = 6'h04;
    localparam logic [5:0] OFS_B_COUNT = 6'h08;
    localparam logic [5:0] OFS_R_COUNT = 6'h0c;
    localparam logic [5:0] OFS_DELAY = 6'h10;
    localparam logic [5:0] OFS_LOCK_CFG = 6'h14;
    localparam logic [5:0] OFS_PIN_SEL = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h1c;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h20;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h24;

    // ------------------------------------------------------------
    // Field widths and positions
    // ------------------------------------------------------------
    localparam int A_W = 6;
    localparam int B_W = 13;
    localparam int R_W = 14;
    localparam int N_W = 18;
    localparam int PH_W = 8;
    localparam int DLY_REF_LSB = 0;
    localparam int DLY_REF_EN = 3;
    localparam int DLY_FB_LSB = 4;
    localparam int DLY_FB_EN = 7;
    localparam int LCK_ABL_LSB = 0;
    localparam int LCK_WIN_BIT = 4;
    localparam int LCK_CNT_LSB = 5;
    localparam int PIN_LD_LSB = 0;
    localparam int PIN_ST_LSB = 2;
    localparam int PIN_RM_LSB = 4;
    localparam int IRQ_GAIN = 0;
    localparam int IRQ_LOSS = 1;
    localparam int IRQ_BADDIV = 2;
    localparam int STS_LOCK = 0;
    localparam int STS_BADDIV = 1;
    localparam int STS_N_LSB = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_PRESCALE = 3'h1;
    localparam logic [A_W-1:0] RST_A_COUNT = 6'h00;
    localparam logic [B_W-1:0] RST_B_COUNT = 13'h0003;
    localparam logic [R_W-1:0] RST_R_COUNT = 14'h0001;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [6:0] RST_LOCK_CFG = 7'h00;
    localparam logic [5:0] RST_PIN_SEL = 6'h00;

    // ------------------------------------------------------------
    // Lock window figures in phase error units, lock counts in detector cycles
    // ------------------------------------------------------------
    localparam logic [PH_W-1:0] LOCK_THR_NARROW = 8'h04;
    localparam logic [PH_W-1:0] LOCK_THR_WIDE = 8'h0c;
    localparam logic [PH_W-1:0] ABL_STEP = 8'h02;
    localparam logic [PH_W-1:0] UNLOCK_MARGIN = 8'h06;
    localparam logic [7:0] LOCK_CNT_SEL0 = 8'h05;
    localparam logic [7:0] LOCK_CNT_SEL1 = 8'h10;
    localparam logic [7:0] LOCK_CNT_SEL2 = 8'h40;
    localparam logic [7:0] LOCK_CNT_SEL3 = 8'hff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PRE_FD1 = 3'h0, PRE_FD2 = 3'h1, PRE_FD3 = 3'h2, PRE_DM2 = 3'h3,
        PRE_DM4 = 3'h4, PRE_DM8 = 3'h5, PRE_DM16 = 3'h6, PRE_DM32 = 3'h7
    } pllddl_pre_t;

    typedef enum logic [1:0] {
        PIN_LOW = 2'h0, PIN_LOCK = 2'h1, PIN_NLOCK = 2'h2, PIN_HIGH = 2'h3
    } pllddl_pinsel_t;

    typedef enum logic [1:0] {
        LD_ACQUIRE = 2'b01, LD_LOCKED = 2'b10
    } pllddl_lock_st_t;

endpackage : pllddl_pkg

//--- verilog/pllddl_pulse_div.sv
`timescale 1ns/1ps
module pllddl_pulse_div #(
    parameter int CNT_W = 18
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic restart_in,
    input wire logic [CNT_W-1:0] ratio_in,
    // Edges in, divided edges out
    input wire logic tick_in,
    output logic pulse_out
);

    logic [CNT_W-1:0] count;
    logic last;

    // Ratio of 0 or 1 passes every edge
    assign last = (ratio_in <= CNT_W'(1)) || (count >= ratio_in - CNT_W'(1));

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= '0;
            pulse_out <= 1'b0;
        end else if (restart_in) begin
            count <= '0;
            pulse_out <= 1'b0;
        end else if (tick_in) begin
            pulse_out <= last;
            count <= last ? '0 : count + CNT_W'(1);
        end else begin
            pulse_out <= 1'b0;
        end
    end

endmodule : pllddl_pulse_div

//--- verilog/pllddl_top.sv
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pllddl_top
    import pllddl_pkg::*;
#(
    parameter logic [PH_W-1:0] P_LOCK_THR_NARROW = LOCK_THR_NARROW,
    parameter logic [PH_W-1:0] P_LOCK_THR_WIDE = LOCK_THR_WIDE,
    parameter logic [PH_W-1:0] P_UNLOCK_MARGIN = UNLOCK_MARGIN
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // Edge events from reference and oscillator
    input wire logic REF_TICK_IN,
    input wire logic FB_TICK_IN,
    // Detector cycle and its measured edge difference
    input wire logic PFD_CYCLE_IN,
    input wire logic [PH_W-1:0] PHASE_ERR_IN,
    // Divided edges to the detector
    output logic REF_PFD_OUT,
    output logic FB_PFD_OUT,
    // Delay cell controls
    output logic [2:0] REF_DELAY_SEL_OUT,
    output logic REF_DELAY_EN_OUT,
    output logic [2:0] FB_DELAY_SEL_OUT,
    output logic FB_DELAY_EN_OUT,
    // Output pins and interrupt
    output logic LOCK_INDICATOR_PIN_OUT,
    output logic STATUS_PIN_OUT,
    output logic REFERENCE_MONITOR_PIN_OUT,
    output logic IRQ_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] pre_mode;
    logic [A_W-1:0] a_count;
    logic [B_W-1:0] b_count;
    logic [R_W-1:0] r_count;
    logic [7:0] delay_cfg;
    logic [6:0] lock_cfg;
    logic [5:0] pin_sel;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [N_W-1:0] n_ratio;
    logic [N_W-1:0] next_n;
    logic [N_W-1:0] p_value;
    logic dual_mode;
    logic bad_div;
    logic bad_div_d;
    logic cfg_change;
    logic wr_fire;
    logic rd_take;
    logic [31:0] wr_merged;
    logic [31:0] next_rdata;
    logic [R_W-1:0] r_eff;
    pllddl_lock_st_t lock_state;
    logic locked;
    logic locked_d;
    logic [7:0] run_cnt;
    logic [7:0] need_cnt;
    logic [PH_W-1:0] lock_thr;
    logic [PH_W-1:0] unlock_thr;
    logic in_window;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // One wait state: request seen, then answer with waitrequest low
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
        end else if ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT) begin
            AVS_WAITREQUEST_OUT <= 1'b0;
        end else begin
            AVS_WAITREQUEST_OUT <= 1'b1;
        end
    end

    assign wr_fire = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
    assign rd_take = AVS_READ_IN && AVS_WAITREQUEST_OUT;

    function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_val & ~m) | (new_val & m);
    endfunction : be_merge

    always_comb begin
        unique case (AVS_ADDRESS_IN)
            OFS_PRESCALE: wr_merged = {29'h0, pre_mode};
            OFS_A_COUNT: wr_merged = {26'h0, a_count};
            OFS_B_COUNT: wr_merged = {19'h0, b_count};
            OFS_R_COUNT: wr_merged = {18'h0, r_count};
            OFS_DELAY: wr_merged = {24'h0, delay_cfg};
            OFS_LOCK_CFG: wr_merged = {25'h0, lock_cfg};
            OFS_PIN_SEL: wr_merged = {26'h0, pin_sel};
            OFS_IRQ_MASK: wr_merged = {29'h0, irq_mask};
            default: wr_merged = 32'h0;
        endcase
        wr_merged = be_merge(wr_merged, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pre_mode <= RST_PRESCALE;
            a_count <= RST_A_COUNT;
            b_count <= RST_B_COUNT;
            r_count <= RST_R_COUNT;
            delay_cfg <= RST_DELAY;
            lock_cfg <= RST_LOCK_CFG;
            pin_sel <= RST_PIN_SEL;
            irq_mask <= 3'h0;
        end else if (wr_fire) begin
            unique case (AVS_ADDRESS_IN)
                OFS_PRESCALE: pre_mode <= wr_merged[2:0];
                OFS_A_COUNT: a_count <= wr_merged[A_W-1:0];
                OFS_B_COUNT: b_count <= wr_merged[B_W-1:0];
                OFS_R_COUNT: r_count <= wr_merged[R_W-1:0];
                OFS_DELAY: delay_cfg <= wr_merged[7:0];
                OFS_LOCK_CFG: lock_cfg <= wr_merged[6:0];
                OFS_PIN_SEL: pin_sel <= wr_merged[5:0];
                OFS_IRQ_MASK: irq_mask <= wr_merged[2:0];
                default: ;
            endcase
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        unique case (AVS_ADDRESS_IN)
            OFS_PRESCALE: next_rdata = {29'h0, pre_mode};
            OFS_A_COUNT: next_rdata = {26'h0, a_count};
            OFS_B_COUNT: next_rdata = {19'h0, b_count};
            OFS_R_COUNT: next_rdata = {18'h0, r_count};
            OFS_DELAY: next_rdata = {24'h0, delay_cfg};
            OFS_LOCK_CFG: next_rdata = {25'h0, lock_cfg};
            OFS_PIN_SEL: next_rdata = {26'h0, pin_sel};
            OFS_STATUS: next_rdata = {6'h0, n_ratio, 6'h0, bad_div, locked};
            OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
            OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            AVS_READDATA_OUT <= 32'h0;
        end else if (rd_take) begin
            AVS_READDATA_OUT <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Feedback divide ratio
    // ------------------------------------------------------------
    always_comb begin
        unique case (pre_mode)
            PRE_FD1: p_value = 18'h00001;
            PRE_FD2, PRE_DM2: p_value = 18'h00002;
            PRE_FD3: p_value = 18'h00003;
            PRE_DM4: p_value = 18'h00004;
            PRE_DM8: p_value = 18'h00008;
            PRE_DM16: p_value = 18'h00010;
            PRE_DM32: p_value = 18'h00020;
        endcase
    end

    assign dual_mode = pre_mode >= PRE_DM2;

    always_comb begin
        if (b_count == B_W'(1)) begin
            next_n = p_value;
        end else if (dual_mode) begin
            next_n = p_value * N_W'(b_count) + N_W'(a_count);
        end else begin
            next_n = p_value * N_W'(b_count);
        end
    end

    // A above B in dual mode is flagged, not corrected
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            n_ratio <= N_W'(0);
            bad_div <= 1'b0;
            bad_div_d <= 1'b0;
        end else begin
            n_ratio <= next_n;
            bad_div <= dual_mode && (B_W'(a_count) > b_count);
            bad_div_d <= bad_div;
        end
    end

    // Divider setting writes restart dividers and lock search
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cfg_change <= 1'b1;
        end else begin
            cfg_change <= wr_fire && (AVS_ADDRESS_IN == OFS_PRESCALE
                || AVS_ADDRESS_IN == OFS_A_COUNT || AVS_ADDRESS_IN == OFS_B_COUNT
                || AVS_ADDRESS_IN == OFS_R_COUNT);
        end
    end

    // R of 0 and 1 both divide by one
    assign r_eff = (r_count == R_W'(0)) ? R_W'(1) : r_count;

    pllddl_pulse_div #(.CNT_W(R_W)) u_ref_div (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .restart_in(cfg_change),
        .ratio_in(r_eff),
        .tick_in(REF_TICK_IN),
        .pulse_out(REF_PFD_OUT)
    );

    pllddl_pulse_div #(.CNT_W(N_W)) u_fb_div (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .restart_in(cfg_change),
        .ratio_in(n_ratio),
        .tick_in(FB_TICK_IN),
        .pulse_out(FB_PFD_OUT)
    );

    // ------------------------------------------------------------
    // Delay cells
    // ------------------------------------------------------------
    // A disabled cell gets code zero so no stale trim leaks through
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REF_DELAY_SEL_OUT <= 3'h0;
            REF_DELAY_EN_OUT <= 1'b0;
            FB_DELAY_SEL_OUT <= 3'h0;
            FB_DELAY_EN_OUT <= 1'b0;
        end else begin
            REF_DELAY_EN_OUT <= delay_cfg[DLY_REF_EN];
            FB_DELAY_EN_OUT <= delay_cfg[DLY_FB_EN];
            REF_DELAY_SEL_OUT <= delay_cfg[DLY_REF_EN] ?
                delay_cfg[DLY_REF_LSB +: 3] : 3'h0;
            FB_DELAY_SEL_OUT <= delay_cfg[DLY_FB_EN] ?
                delay_cfg[DLY_FB_LSB +: 3] : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Lock detector
    // ------------------------------------------------------------
    always_comb begin
        lock_thr = (lock_cfg[LCK_WIN_BIT] ? P_LOCK_THR_WIDE : P_LOCK_THR_NARROW)
            + PH_W'(lock_cfg[LCK_ABL_LSB +: 2] * ABL_STEP);
        unlock_thr = lock_thr + P_UNLOCK_MARGIN
            + PH_W'(lock_cfg[LCK_CNT_LSB +: 2]);
        unique case (lock_cfg[LCK_CNT_LSB +: 2])
            2'h0: need_cnt = LOCK_CNT_SEL0;
            2'h1: need_cnt = LOCK_CNT_SEL1;
            2'h2: need_cnt = LOCK_CNT_SEL2;
            2'h3: need_cnt = LOCK_CNT_SEL3;
        endcase
    end

    assign in_window = PHASE_ERR_IN < lock_thr;
    assign locked = lock_state == LD_LOCKED;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            lock_state <= LD_ACQUIRE;
            run_cnt <= 8'h00;
        end else if (cfg_change) begin
            lock_state <= LD_ACQUIRE;
            run_cnt <= 8'h00;
        end else if (PFD_CYCLE_IN) begin
            unique case (lock_state)
                LD_ACQUIRE: begin
                    if (!in_window) begin
                        run_cnt <= 8'h00;
                    end else if (run_cnt >= need_cnt - 8'h01) begin
                        lock_state <= LD_LOCKED;
                        run_cnt <= 8'h00;
                    end else begin
                        run_cnt <= run_cnt + 8'h01;
                    end
                end
                LD_LOCKED: begin
                    if (PHASE_ERR_IN > unlock_thr) begin
                        lock_state <= LD_ACQUIRE;
                    end
                end
                default: begin
                    lock_state <= LD_ACQUIRE;
                    run_cnt <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    function automatic logic pin_drive(input logic [1:0] sel, input logic lk);
        unique case (pllddl_pinsel_t'(sel))
            PIN_LOW: return 1'b0;
            PIN_LOCK: return lk;
            PIN_NLOCK: return !lk;
            PIN_HIGH: return 1'b1;
        endcase
    endfunction : pin_drive

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            LOCK_INDICATOR_PIN_OUT <= 1'b0;
            STATUS_PIN_OUT <= 1'b0;
            REFERENCE_MONITOR_PIN_OUT <= 1'b0;
        end else begin
            LOCK_INDICATOR_PIN_OUT <= pin_drive(pin_sel[PIN_LD_LSB +: 2], locked);
            STATUS_PIN_OUT <= pin_drive(pin_sel[PIN_ST_LSB +: 2], locked);
            REFERENCE_MONITOR_PIN_OUT <= pin_drive(pin_sel[PIN_RM_LSB +: 2], locked);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_set[IRQ_GAIN] = locked && !locked_d;
    assign irq_set[IRQ_LOSS] = !locked && locked_d;
    assign irq_set[IRQ_BADDIV] = bad_div && !bad_div_d;
    assign irq_clr = (wr_fire && AVS_ADDRESS_IN == OFS_IRQ_STAT && AVS_BYTEENABLE_IN[0]) ?
        AVS_WRITEDATA_IN[2:0] : 3'h0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            locked_d <= 1'b0;
            irq_stat <= 3'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            locked_d <= locked;
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            IRQ_OUT <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    delay_gate_a: assert property (!delay_cfg[DLY_REF_EN] && !delay_cfg[DLY_FB_EN]
        |=> REF_DELAY_SEL_OUT == 3'h0 && FB_DELAY_SEL_OUT == 3'h0
            && !REF_DELAY_EN_OUT && !FB_DELAY_EN_OUT)
        else $error("disabled delay cell still drives a code");

    bypass_ratio_a: assert property (b_count == B_W'(1) && $stable(pre_mode)
        |=> n_ratio == $past(p_value))
        else $error("B of one does not give divide equal to P");

    fixed_ratio_a: assert property (!dual_mode && b_count != B_W'(1)
        |=> n_ratio == $past(p_value) * N_W'($past(b_count)))
        else $error("fixed mode divide is not P times B");

    dual_ratio_a: assert property (dual_mode && b_count != B_W'(1)
        |=> n_ratio == $past(p_value) * N_W'($past(b_count)) + N_W'($past(a_count)))
        else $error("dual mode divide is not P times B plus A");

    pin_route_a: assert property (pin_sel[PIN_LD_LSB +: 2] == PIN_LOCK
        |=> LOCK_INDICATOR_PIN_OUT == $past(locked))
        else $error("lock pin does not follow lock indication");

    lock_count_a: assert property (!cfg_change && PFD_CYCLE_IN && !locked && in_window
        && run_cnt < need_cnt - 8'h01 |=> !locked)
        else $error("lock declared before enough in-window cycles");

    lock_gain_a: assert property (!cfg_change && PFD_CYCLE_IN && !locked && in_window
        && run_cnt == need_cnt - 8'h01 |=> locked ##1 irq_stat[IRQ_GAIN])
        else $error("lock not declared after enough in-window cycles");

    unlock_drop_a: assert property (!cfg_change && PFD_CYCLE_IN && locked
        && PHASE_ERR_IN > unlock_thr |=> !locked)
        else $error("lock held past an out-of-window cycle");

    lock_hold_a: assert property (!cfg_change && locked && !(PFD_CYCLE_IN
        && PHASE_ERR_IN > unlock_thr) |=> locked)
        else $error("lock dropped without an unlock cycle");

    window_order_a: assert property (unlock_thr > lock_thr)
        else $error("unlock window not wider than lock window");

    cfg_restart_a: assert property (cfg_change |=> !locked && run_cnt == 8'h00)
        else $error("divider change did not restart lock search");

endmodule : pllddl_top

//--- testbench/pllddl_host.sv
`timescale 1ns/1ps
module pllddl_host
    import pllddl_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Avalon-MM master
    output logic [ADDR_W-1:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    output logic [3:0] byteenable_out,
    input wire logic [31:0] readdata_in,
    input wire logic waitrequest_in
);
    initial begin
        address_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = '0;
        byteenable_out = 4'hf;
    end

    // Software keeps limits; the invalid-divider case sets A above B, and writing A before B does so briefly in the DM8 and DM32 cases
    task automatic xfer(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge clk_in);
        address_out <= adr;
        writedata_out <= wd;
        write_out <= wr;
        read_out <= !wr;
        while (ok !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
            ok = !waitrequest_in;
        end
        rdat = readdata_in;
        write_out <= 1'b0;
        read_out <= 1'b0;
    endtask : xfer
endmodule : pllddl_host

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import pllddl_pkg::*;
;
    logic CLK_IN = 1'b0, RESETN_IN = 1'b0, REF_TICK_IN = 1'b0, FB_TICK_IN = 1'b0;
    logic PFD_CYCLE_IN = 1'b0, AVS_READ_IN, AVS_WRITE_IN, AVS_WAITREQUEST_OUT;
    logic [PH_W-1:0] PHASE_ERR_IN = '0;
    logic [5:0] AVS_ADDRESS_IN;
    logic [3:0] AVS_BYTEENABLE_IN;
    logic [31:0] AVS_WRITEDATA_IN, AVS_READDATA_OUT;
    logic REF_PFD_OUT, FB_PFD_OUT, REF_DELAY_EN_OUT, FB_DELAY_EN_OUT, IRQ_OUT;
    logic LOCK_INDICATOR_PIN_OUT, STATUS_PIN_OUT, REFERENCE_MONITOR_PIN_OUT;
    logic [2:0] REF_DELAY_SEL_OUT, FB_DELAY_SEL_OUT;
    int mismatches = 0, n_tests = 0;
    always #50 CLK_IN = ~CLK_IN;
    pllddl_top i_dut (.*);
    pllddl_host i_host (.clk_in(CLK_IN), .address_out(AVS_ADDRESS_IN),
        .read_out(AVS_READ_IN), .write_out(AVS_WRITE_IN), .writedata_out(AVS_WRITEDATA_IN),
        .byteenable_out(AVS_BYTEENABLE_IN), .readdata_in(AVS_READDATA_OUT),
        .waitrequest_in(AVS_WAITREQUEST_OUT));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        logic ok;
        i_host.xfer(w, a, d, r, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rdchk(input string what, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, exp, r);
    endtask : rdchk
    // Both tick inputs pulse n times back to back; pulses are counted
    task automatic ticks(input int n, input int er, input int ef);
        int nr, nf;
        nr = 0;
        nf = 0;
        for (int i = 0; i < n + 3; i++) begin
            @(posedge CLK_IN);
            nr += (REF_PFD_OUT === 1'b1);
            nf += (FB_PFD_OUT === 1'b1);
            REF_TICK_IN <= (i < n);
            FB_TICK_IN <= (i < n);
        end
        chk("ref pulses", er, nr);
        chk("fb pulses", ef, nf);
    endtask : ticks
    task automatic phase_frequency_detector(input int n, input logic [7:0] err, input logic l);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK_IN);
            PFD_CYCLE_IN <= 1'b1;
            PHASE_ERR_IN <= err;
        end
        @(posedge CLK_IN);
        PFD_CYCLE_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        chk("pins", {29'h0, l, !l, 1'b1}, {29'h0, LOCK_INDICATOR_PIN_OUT, STATUS_PIN_OUT,
            REFERENCE_MONITOR_PIN_OUT});
    endtask : phase_frequency_detector
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk("prescale", OFS_PRESCALE, 32'h1);
        rdchk("status", OFS_STATUS, 32'h600);
        rdchk("unmapped", 6'h28, 32'h0);
        wr(OFS_STATUS, 32'h1);
        rdchk("status ro", OFS_STATUS, 32'h600);
    endtask : t_reset
    task automatic t_divide();
        // Case word: prescale code, A, B, expected ratio
        logic [31:0] tbl [8] = '{32'h0000_1001, 32'h1000_1002, 32'h4000_1004,
            32'h2020_500f, 32'h3010_3007, 32'h5071_2097, 32'h6070_9097, 32'h7165_4a96};
        foreach (tbl[i]) begin
            wr(OFS_PRESCALE, {29'h0, tbl[i][30:28]});
            wr(OFS_A_COUNT, {24'h0, tbl[i][27:20]});
            wr(OFS_B_COUNT, {24'h0, tbl[i][19:12]});
            rdchk("ratio", OFS_STATUS, {12'h0, tbl[i][11:0], 8'h0});
        end
        wr(OFS_PRESCALE, 32'h4);
        wr(OFS_A_COUNT, 32'h5);
        wr(OFS_B_COUNT, 32'h3);
        rdchk("bad div", OFS_STATUS, 32'h1102);
        rdchk("irq bad", OFS_IRQ_STAT, 32'h4);
        wr(OFS_IRQ_STAT, 32'h4);
        rdchk("irq clr", OFS_IRQ_STAT, 32'h0);
        wr(OFS_PRESCALE, 32'h0);
        wr(OFS_A_COUNT, 32'h0);
        wr(OFS_R_COUNT, 32'h5);
        ticks(15, 3, 5);
    endtask : t_divide
    task automatic t_delay();
        wr(OFS_DELAY, 32'hd5);
        repeat (2) @(posedge CLK_IN);
        chk("delay", 32'h0b, {REF_DELAY_SEL_OUT, REF_DELAY_EN_OUT, FB_DELAY_SEL_OUT,
            FB_DELAY_EN_OUT});
        wr(OFS_DELAY, 32'h3b);
        repeat (2) @(posedge CLK_IN);
        chk("delay", 32'h70, {REF_DELAY_SEL_OUT, REF_DELAY_EN_OUT, FB_DELAY_SEL_OUT,
            FB_DELAY_EN_OUT});
    endtask : t_delay
    task automatic t_lock();
        wr(OFS_PIN_SEL, 32'h39);
        wr(OFS_IRQ_MASK, 32'h3);
        phase_frequency_detector(4, 8'h03, 1'b0);
        phase_frequency_detector(1, 8'h04, 1'b0);
        phase_frequency_detector(4, 8'h03, 1'b0);
        phase_frequency_detector(1, 8'h03, 1'b1);
        // Interrupt line settles one edge after the pins
        @(posedge CLK_IN);
        chk("irq", 32'h1, {31'h0, IRQ_OUT});
        phase_frequency_detector(1, 8'h0a, 1'b1);
        phase_frequency_detector(1, 8'h0b, 1'b0);
        rdchk("irq stat", OFS_IRQ_STAT, 32'h3);
        wr(OFS_IRQ_STAT, 32'h3);
        wr(OFS_LOCK_CFG, 32'h33);
        phase_frequency_detector(15, 8'h11, 1'b0);
        phase_frequency_detector(1, 8'h11, 1'b1);
        phase_frequency_detector(1, 8'h19, 1'b1);
        phase_frequency_detector(1, 8'h1a, 1'b0);
        chk("irq", 32'h1, {31'h0, IRQ_OUT});
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge CLK_IN);
        chk("irq mask", 32'h0, {31'h0, IRQ_OUT});
        phase_frequency_detector(16, 8'h00, 1'b1);
        wr(OFS_B_COUNT, 32'h3);
        // Restart flop, lock state, then pin: three edges after the write
        repeat (3) @(posedge CLK_IN);
        chk("relock", 32'h0, {31'h0, LOCK_INDICATOR_PIN_OUT});
        wr(OFS_PIN_SEL, 32'h06);
        repeat (2) @(posedge CLK_IN);
        chk("pin low", 32'h4, {29'h0, LOCK_INDICATOR_PIN_OUT, STATUS_PIN_OUT,
            REFERENCE_MONITOR_PIN_OUT});
    endtask : t_lock
    initial begin
        repeat (8) @(posedge CLK_IN);
        RESETN_IN <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        t_reset();
        t_divide();
        t_delay();
        t_lock();
        close_out();
    end
endmodule : tb_top
